//--- hcbp_cfg.svh
// Constants of the host processor bus port: widths, timing counts, modes.
// Assumes inclusion by the package, the port modules, the host model and the testbench top.
// Notes on behaviour
// RULE1: Access only while device select is low.
// RULE2: Read strobe marks a read cycle.
// RULE3: Store strobe captures a register write.
// RULE4: Data strobe read drives valid read data.
// RULE5: Direction select chooses read or write.
// RULE6: Latch transparent while latch strobe high.
// RULE7: Address held at latch strobe falling edge.
// RULE8: Latch strobe tied low/high picks bus style.
// RULE9: Width select low 8 bits, high 16.
// RULE10: Irq output push-pull either polarity, or open-drain.
// RULE11: Irq asserted while service needed; sharable.
// RULE12: Board ties address inputs to data bus.
// RULE13: Multiplexed and demultiplexed 8-bit operation supported.
// RULE14: Unused general port becomes upper data lines.
// RULE15: System reset forces whole port to reset.
// RULE16: Upper byte on general port; inputs after reset.
// RULE17: Demultiplexed address from address inputs directly.
`ifndef HCBP_CFG_SVH
`define HCBP_CFG_SVH
`define HCBP_ADDR_W 5
`define HCBP_DATA_W 16
`define HCBP_BYTE_W 8
`define HCBP_REG_N 32
// Cycles the latch strobe must sit still before its level sets the style
`define HCBP_STYLE_HOLD 8'h10
`define HCBP_IRQ_PP_HIGH 2'h0
`define HCBP_IRQ_PP_LOW 2'h1
`define HCBP_IRQ_OD 2'h2
`endif

//--- hcbp_pkg.sv
// Types of the host processor bus port.
// Assumes hcbp_cfg.svh is on the include path.
`include "hcbp_cfg.svh"
package hcbp_pkg;
   typedef enum logic [3:0] {
      HCBP_IDLE = 4'h1,
      HCBP_READ = 4'h2,
      HCBP_WRITE = 4'h4,
      HCBP_DONE = 4'h8
   } hcbp_state_t;
   // One request toward the register store
   typedef struct packed {
      logic wr;
      logic rd;
      logic wide;
      logic [`HCBP_ADDR_W-1:0] addr;
      logic [`HCBP_DATA_W-1:0] data;
   } hcbp_req_t;
   // Synchronised host pins
   typedef struct packed {
      logic cs_n;
      logic rd_n;
      logic wr_n;
      logic ale;
      logic wide;
      logic [`HCBP_ADDR_W-1:0] addr;
      logic [`HCBP_DATA_W-1:0] data;
   } hcbp_pins_t;
endpackage

//--- hcbp_regmem.sv
// Register store of the host port: 32 words of 16 bits, registered read.
// Assumes one clock and requests already decoded by the port logic.
`timescale 1ns/1ps
`include "hcbp_cfg.svh"
module hcbp_regmem
   import hcbp_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // Access
   input wire hcbp_req_t req,
   output logic [`HCBP_DATA_W-1:0] rdata
);
   logic [`HCBP_DATA_W-1:0] mem [`HCBP_REG_N];
   logic [`HCBP_DATA_W-1:0] rdata_next;

   // Read data selected combinationally, registered below
   always_comb begin
      rdata_next = mem[req.addr];
   end

   // Narrow writes touch only the low byte
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         for (int i = 0; i < `HCBP_REG_N; i++) begin
            mem[i] <= 16'h0000;
         end
         rdata <= 16'h0000;
      end else begin
         if (req.wr) begin
            mem[req.addr][7:0] <= req.data[7:0];
            if (req.wide) begin
               mem[req.addr][15:8] <= req.data[15:8];
            end
         end
         rdata <= rdata_next;
      end
   end
endmodule

//--- hcbp_port.sv
// Host processor bus port: strobe decode, address latch, data drive, irq.
// Assumes host pins are asynchronous to core_clk; service request is local.
`timescale 1ns/1ps
`include "hcbp_cfg.svh"
module hcbp_port
   import hcbp_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // Host control pins
   input wire logic cs_n,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic ale,
   input wire logic wide_bus_select,
   input wire logic mux_mode,
   input wire logic [`HCBP_ADDR_W-1:0] addr_in,
   // Data pins, low byte and general port
   input wire logic [`HCBP_BYTE_W-1:0] data_in,
   output logic [`HCBP_BYTE_W-1:0] data_out,
   output logic data_oe_n,
   input wire logic [`HCBP_BYTE_W-1:0] gp_in,
   output logic [`HCBP_BYTE_W-1:0] gp_out,
   output logic gp_oe_n,
   // Interrupt
   input wire logic service_req,
   input wire logic [1:0] irq_mode,
   output logic irq_out,
   output logic irq_oe_n,
   // Status
   output logic style_strobe_pair
);
   hcbp_pins_t s1_reg, s2_reg, s1_next, s2_next;
   hcbp_state_t state_reg, state_next;
   logic [`HCBP_ADDR_W-1:0] alat_reg, alat_next;
   logic ale_prev_reg, ale_prev_next;
   logic [7:0] still_reg, still_next;
   logic pair_reg, pair_next;
   hcbp_req_t req;
   logic [`HCBP_DATA_W-1:0] rdata;
   logic [`HCBP_BYTE_W-1:0] dout_next, gout_next;
   logic doe_next, goe_next, irq_next, irqoe_next;
   logic is_rd, is_wr;
   logic [`HCBP_ADDR_W-1:0] cur_addr;

   // Irq pin level for a request level in a given mode
   function automatic logic [1:0] irq_drive(input logic need,
                                            input logic [1:0] mode);
      unique case (mode)
         `HCBP_IRQ_PP_LOW: irq_drive = {~need, 1'b0};
         `HCBP_IRQ_OD: irq_drive = {1'b0, ~need};
         default: irq_drive = {need, 1'b0};
      endcase
   endfunction

   // Two-flop synchroniser of all host pins but mux_mode; stage one feeds stage two only
   always_comb begin
      s1_next = '{cs_n: cs_n, rd_n: rd_n, wr_n: wr_n, ale: ale,
                  wide: wide_bus_select, addr: addr_in,
                  data: {gp_in, data_in}};
      s2_next = s1_reg;
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         s1_reg <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, default: '0};
         s2_reg <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, default: '0};
      end else begin
         s1_reg <= s1_next;
         s2_reg <= s2_next;
      end
   end

   // Style detect: a latch strobe that never moves is a strap; a moving
   // one means multiplexed strobe-pair use
   always_comb begin
      ale_prev_next = s2_reg.ale;
      still_next = still_reg;
      pair_next = pair_reg;
      if (s2_reg.ale != ale_prev_reg) begin
         still_next = 8'h00;
         pair_next = 1'b1;
      end else if (still_reg != `HCBP_STYLE_HOLD) begin
         still_next = still_reg + 8'h01;
      end else if (!mux_mode) begin
         pair_next = s2_reg.ale; // see RULE8
      end
   end

   // Address latch: transparent while strobe high, held on its fall
   always_comb begin
      alat_next = alat_reg;
      if (s2_reg.ale) begin
         alat_next = s2_reg.data[`HCBP_ADDR_W-1:0]; // see RULE6 RULE12
      end
      // see RULE7
      cur_addr = mux_mode ? alat_reg : s2_reg.addr; // see RULE17 RULE13
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         ale_prev_reg <= 1'b0;
         still_reg <= 8'h00;
         pair_reg <= 1'b1;
         alat_reg <= 5'h00;
      end else begin
         ale_prev_reg <= ale_prev_next;
         still_reg <= still_next;
         pair_reg <= pair_next;
         alat_reg <= alat_next;
      end
   end

   // Cycle decode per bus style
   always_comb begin
      if (pair_reg) begin
         is_rd = !s2_reg.rd_n; // see RULE2
         is_wr = !s2_reg.wr_n; // see RULE3
      end else begin
         // Direction high means read
         is_rd = !s2_reg.rd_n && s2_reg.wr_n; // see RULE5 RULE4
         is_wr = !s2_reg.rd_n && !s2_reg.wr_n; // see RULE5
      end
   end

   // One access per strobe; the write lands on the strobe's leading edge
   always_comb begin
      state_next = state_reg;
      req = '{wr: 1'b0, rd: 1'b0, wide: s2_reg.wide, addr: cur_addr,
              data: s2_reg.data};
      unique case (state_reg)
         HCBP_IDLE: begin
            if (!s2_reg.cs_n && is_wr) begin // see RULE1
               state_next = HCBP_WRITE;
            end else if (!s2_reg.cs_n && is_rd) begin
               state_next = HCBP_READ;
            end
         end
         HCBP_WRITE: begin
            req.wr = 1'b1; // see RULE3 RULE9
            state_next = HCBP_DONE;
         end
         HCBP_READ: begin
            req.rd = 1'b1;
            if (s2_reg.cs_n || !is_rd) begin
               state_next = HCBP_IDLE;
            end
         end
         HCBP_DONE: begin
            if (s2_reg.cs_n || (!is_wr && !is_rd)) begin
               state_next = HCBP_IDLE;
            end
         end
         default: state_next = HCBP_IDLE;
      endcase
   end

   hcbp_regmem u_mem (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .req(req),
      .rdata(rdata)
   );

   // Output drive: data only during a selected read; upper byte only wide
   always_comb begin
      doe_next = !(state_reg == HCBP_READ && !s2_reg.cs_n && is_rd);
      dout_next = rdata[7:0]; // see RULE4
      goe_next = doe_next || !s2_reg.wide; // see RULE14 RULE16 RULE9
      gout_next = rdata[15:8];
      {irq_next, irqoe_next} = irq_drive(service_req, irq_mode);
   end

   // Reset leaves every pin released, upper lines as inputs
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin // see RULE15
         state_reg <= HCBP_IDLE;
         data_out <= 8'h00;
         data_oe_n <= 1'b1;
         gp_out <= 8'h00;
         gp_oe_n <= 1'b1; // see RULE16
         irq_out <= 1'b0;
         irq_oe_n <= 1'b1;
         style_strobe_pair <= 1'b1;
      end else begin
         state_reg <= state_next;
         data_out <= dout_next;
         data_oe_n <= doe_next;
         gp_out <= gout_next;
         gp_oe_n <= goe_next;
         irq_out <= irq_next; // see RULE10 RULE11
         irq_oe_n <= irqoe_next;
         style_strobe_pair <= pair_reg;
      end
   end

   // Checks
   wr_select_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      req.wr |-> $past(!s2_reg.cs_n)) // see RULE1
      else $error("write without select");
   rd_drive_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      !data_oe_n |-> $past(state_reg == HCBP_READ && !s2_reg.cs_n))
      // see RULE4
      else $error("data driven outside read");
   pair_write_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      (state_reg == HCBP_IDLE && pair_reg && !s2_reg.cs_n && !s2_reg.wr_n)
      |=> req.wr) // see RULE3
      else $error("strobe write missed");
   pair_read_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      (state_reg == HCBP_IDLE && pair_reg && !s2_reg.cs_n && s2_reg.wr_n
       && !s2_reg.rd_n) |=> state_reg == HCBP_READ) // see RULE2
      else $error("read strobe missed");
   dir_sel_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      (state_reg == HCBP_IDLE && !pair_reg && !s2_reg.cs_n && !s2_reg.rd_n
       && s2_reg.wr_n) |=> state_reg == HCBP_READ) // see RULE5
      else $error("direction not followed");
   latch_pass_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      s2_reg.ale |=> alat_reg == $past(s2_reg.data[4:0])) // see RULE6
      else $error("latch not transparent");
   latch_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      !s2_reg.ale |=> alat_reg == $past(alat_reg)) // see RULE7
      else $error("latch changed while closed");
   wide_off_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      !$past(s2_reg.wide) |-> gp_oe_n) // see RULE9
      else $error("upper byte driven in narrow mode");
   irq_od_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      $past(reset_n) && $past(irq_mode) == `HCBP_IRQ_OD |-> !irq_out
      && irq_oe_n == !$past(service_req)) // see RULE10 RULE11
      else $error("open-drain irq wrong");
   cov_wr_c: cover property (@(posedge core_clk) req.wr);
   cov_rd_c: cover property (@(posedge core_clk) !data_oe_n);
   cov_wide_c: cover property (@(posedge core_clk) !gp_oe_n);
endmodule

//--- hcbp_host_model.sv
// Bus master model of the host side: strobes, address and both data bytes.
// Assumes the port's data outputs and enables are fed back to it.
`timescale 1ns/1ps
`include "hcbp_cfg.svh"
module hcbp_host_model
   import hcbp_pkg::*;
(
   // Clock and strap
   input wire logic core_clk,
   input wire logic mux_mode,
   // Pins toward the port
   output logic cs_n,
   output logic rd_n,
   output logic wr_n,
   output logic ale,
   output logic [`HCBP_ADDR_W-1:0] addr_in,
   output logic [`HCBP_BYTE_W-1:0] data_in,
   output logic [`HCBP_BYTE_W-1:0] gp_in,
   // Port drive back onto the bus
   input wire logic [`HCBP_BYTE_W-1:0] data_out,
   input wire logic data_oe_n,
   input wire logic [`HCBP_BYTE_W-1:0] gp_out,
   input wire logic gp_oe_n
);
   logic [15:0] hv;
   logic hdrv;
   logic [4:0] ha;

   // Idle bus: strobes and select released
   initial begin
      cs_n = 1'h1;
      rd_n = 1'h1;
      wr_n = 1'h1;
      ale = 1'h0;
      hv = 16'h0000;
      hdrv = 1'h0;
      ha = 5'h00;
   end

   // Released lines show the inverse of the last value, never a stale copy
   always_comb begin
      data_in = !data_oe_n ? data_out : (hdrv ? hv[7:0] : ~hv[7:0]);
      gp_in = !gp_oe_n ? gp_out : (hdrv ? hv[15:8] : ~hv[15:8]);
      addr_in = mux_mode ? data_in[4:0] : ha;
   end

   // Waits n edges, then moves off the edge
   task automatic step(input int n);
      repeat (n) @(posedge core_clk);
      #2;
   endtask

   // One access in either style; the request holds until release
   task automatic access(input logic sel, input logic wr, input logic ds,
      input logic [4:0] a, input logic [15:0] d, output logic [15:0] q);
      ha = a;
      hdrv = 1'h1;
      hv = {11'h000, a};
      if (mux_mode) begin
         ale = 1'h1;
         step(4);
         ale = 1'h0;
         step(4);
      end
      hv = d;
      hdrv = wr;
      wr_n = !wr;
      rd_n = wr && !ds;
      cs_n = !sel;
      step(8);
      q = {gp_in, data_in};
      cs_n = 1'h1;
      rd_n = 1'h1;
      wr_n = 1'h1;
      hdrv = 1'h0;
      step(4);
   endtask
endmodule

//--- hcbp_port_tb_top.sv
// Testbench of the host port: hand-written cases before and after a row loop.
// Assumes the host model is the only bus master.
`timescale 1ns/1ps
`include "hcbp_cfg.svh"
module hcbp_port_tb_top
   import hcbp_pkg::*;
;
   typedef struct packed {
      logic [1:0] mode;
      logic sreq;
      logic eirq;
      logic eoe;
      logic wide;
      logic [4:0] addr;
      logic [15:0] wd;
      logic [15:0] erd;
   } hcbp_row_t;
   // Narrow writes keep the upper byte of what was there
   hcbp_row_t rows [6] = '{
      '{`HCBP_IRQ_PP_HIGH, 1'h1, 1'h1, 1'h0, 1'h1, 5'h00, 16'hA55A, 16'hA55A},
      '{`HCBP_IRQ_PP_HIGH, 1'h0, 1'h0, 1'h0, 1'h0, 5'h00, 16'h123C, 16'hA53C},
      '{`HCBP_IRQ_PP_LOW, 1'h1, 1'h0, 1'h0, 1'h1, 5'h1F, 16'hFFFF, 16'hFFFF},
      '{`HCBP_IRQ_PP_LOW, 1'h0, 1'h1, 1'h0, 1'h0, 5'h01, 16'hC381, 16'h0081},
      '{`HCBP_IRQ_OD, 1'h1, 1'h0, 1'h0, 1'h1, 5'h10, 16'h0F0E, 16'h0F0E},
      '{`HCBP_IRQ_OD, 1'h0, 1'h0, 1'h1, 1'h0, 5'h1F, 16'h0000, 16'hFF00}};
   logic core_clk;
   logic reset_n = 1'h0;
   logic wide_bus_select = 1'h1;
   logic mux_mode = 1'h0;
   logic service_req = 1'h0;
   logic [1:0] irq_mode = `HCBP_IRQ_PP_HIGH;
   logic cs_n, rd_n, wr_n, ale, data_oe_n, gp_oe_n;
   logic irq_out, irq_oe_n, style_strobe_pair;
   logic [4:0] addr_in;
   logic [7:0] data_in, data_out, gp_in, gp_out;
   logic [15:0] q;
   int bad_count = 0;
   int n_checks = 0;

   hcbp_port hcbp_port_inst(.core_clk, .reset_n, .cs_n, .rd_n, .wr_n,
      .ale, .wide_bus_select, .mux_mode, .addr_in, .data_in, .data_out,
      .data_oe_n, .gp_in, .gp_out, .gp_oe_n, .service_req, .irq_mode,
      .irq_out, .irq_oe_n, .style_strobe_pair);
   hcbp_host_model hcbp_host_model_inst(.core_clk, .mux_mode, .cs_n,
      .rd_n, .wr_n, .ale, .addr_in, .data_in, .gp_in, .data_out,
      .data_oe_n, .gp_out, .gp_oe_n);

   // 40 MHz clock
   initial begin
      core_clk = 1'h0;
      forever #12.5 core_clk = ~core_clk;
   end

   // Compare tasks, one per result width
   task automatic chk_word(input string what, input logic [15:0] e,
      input logic [15:0] g);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic chk_bit(input string what, input logic e, input logic g);
      chk_word(what, {15'h0000, e}, {15'h0000, g});
   endtask

   // Verdict, reached from the main sequence or the watchdog
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Watchdog well past the expected run of about 290 cycles
   initial begin
      repeat (5000) @(posedge core_clk);
      bad_count++;
      final_report();
   end

   // Main sequence
   initial begin
      hcbp_host_model_inst.step(3);
      chk_bit("data_oe_n", 1'h1, data_oe_n);
      chk_bit("gp_oe_n", 1'h1, gp_oe_n);
      chk_bit("irq_oe_n", 1'h1, irq_oe_n);
      reset_n = 1'h1;
      // Latch strobe parked low picks the data-strobe style
      hcbp_host_model_inst.step(20);
      chk_bit("style", 1'h0, style_strobe_pair);
      hcbp_host_model_inst.access(1'h1, 1'h1, 1'h1, 5'h03, 16'h5AA5, q);
      hcbp_host_model_inst.access(1'h1, 1'h0, 1'h1, 5'h03, 16'h0000, q);
      chk_word("ds read", 16'h5AA5, q);
      hcbp_host_model_inst.ale = 1'h1;
      hcbp_host_model_inst.step(20);
      chk_bit("style", 1'h1, style_strobe_pair);
      foreach (rows[i]) begin
         irq_mode = rows[i].mode;
         service_req = rows[i].sreq;
         wide_bus_select = rows[i].wide;
         hcbp_host_model_inst.access(1'h1, 1'h1, 1'h0, rows[i].addr,
            rows[i].wd, q);
         wide_bus_select = 1'h1;
         hcbp_host_model_inst.access(1'h1, 1'h0, 1'h0, rows[i].addr,
            16'h0000, q);
         chk_word("read", rows[i].erd, q);
         chk_bit("irq_out", rows[i].eirq, irq_out);
         chk_bit("irq_oe_n", rows[i].eoe, irq_oe_n);
      end
      // Write while unselected must be ignored
      hcbp_host_model_inst.access(1'h0, 1'h1, 1'h0, 5'h02, 16'hBEEF, q);
      hcbp_host_model_inst.access(1'h1, 1'h0, 1'h0, 5'h02, 16'h0000, q);
      chk_word("unselected", 16'h0000, q);
      // Multiplexed address through the latch
      mux_mode = 1'h1;
      hcbp_host_model_inst.access(1'h1, 1'h1, 1'h0, 5'h07, 16'h6699, q);
      hcbp_host_model_inst.access(1'h1, 1'h0, 1'h0, 5'h07, 16'h0000, q);
      chk_word("mux read", 16'h6699, q);
      // Mid-run reset clears the store
      reset_n = 1'h0;
      mux_mode = 1'h0;
      hcbp_host_model_inst.ale = 1'h1;
      hcbp_host_model_inst.step(3);
      reset_n = 1'h1;
      hcbp_host_model_inst.access(1'h1, 1'h0, 1'h0, 5'h07, 16'h0000, q);
      chk_word("after reset", 16'h0000, q);
      final_report();
   end
endmodule
